// file: ecas_cfg.svh
`ifndef ECAS_CFG_SVH
`define ECAS_CFG_SVH

// Result and control widths
`define ECAS_RESULT_W 12
`define ECAS_CHAN_W 3
`define ECAS_CNT_W 4
`define ECAS_CHAN_MSB 5
`define ECAS_CHAN_LSB 3
`define ECAS_CHAN_RESET 3'h0

// Cycle positions within one 16-clock conversion
`define ECAS_CTRL_LAST 4'h7
`define ECAS_HOLD_START 4'h3
`define ECAS_LAST_CYCLE 4'hf

// Buffering
`define ECAS_FIFO_DEPTH 32

`endif

// file: ecas_pkg.sv
package ecas_pkg;
  `include "ecas_cfg.svh"

  typedef enum logic [1:0] {
    MODE_POWERDOWN,
    MODE_TRACK,
    MODE_HOLD
  } ecas_mode_type;

  typedef struct packed {
    logic valid;
    logic [`ECAS_RESULT_W-1:0] data;
  } ecas_code_type;

  typedef struct packed {
    logic [`ECAS_CNT_W-1:0] riseCnt;
    logic [6:0] ctrlShift;
  } ecas_rise_type;

  typedef struct packed {
    logic [`ECAS_CHAN_W-1:0] nextChan;
    logic [`ECAS_CHAN_W-1:0] curChan;
  } ecas_chan_type;

  typedef struct packed {
    logic [`ECAS_RESULT_W-1:0] outWord;
    logic bitOut;
    logic track;
    logic pdAuto;
  } ecas_fall_type;

  typedef struct packed {
    logic holdSync1;
    logic holdSync2;
    logic ackTgl;
  } ecas_hs_type;

  typedef struct packed {
    logic [1:0] frameSync;
    logic [1:0] trackSync;
    logic [1:0] pdSync;
    logic [1:0][`ECAS_CHAN_W-1:0] chanSync;
    logic [1:0] ackSync;
    logic [`ECAS_RESULT_W-1:0] resultHold;
    logic holdTgl;
    logic [`ECAS_CHAN_W-1:0] muxSel;
    ecas_mode_type mode;
  } ecas_core_type;
endpackage

// file: ecas_sequencer.sv
`timescale 1ns/100ps
`include "ecas_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Result buffer
module ecas_fifo #(
  parameter int WIDTH = `ECAS_RESULT_W,
  parameter int DEPTH = `ECAS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic inRdy;
    logic outVld;
  } ecas_fifo_type;

  ecas_fifo_type s_reg, s_next;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push = inValid && s_reg.inRdy;
  assign pop = outReady && s_reg.outVld;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = inData;
      s_next.wp = bump(s_reg.wp);
    end
    if (pop) begin
      s_next.rp = bump(s_reg.rp);
    end
    s_next.cnt = s_reg.cnt + CW'(push) - CW'(pop);
    s_next.inRdy = s_next.cnt != CW'(DEPTH);
    s_next.outVld = s_next.cnt != '0;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign inReady = s_reg.inRdy;
  assign outValid = s_reg.outVld;
  assign outData = s_reg.mem[s_reg.rp];
endmodule // ecas_fifo

////////////////////////////////////////////////////////////////////////////
// Serial sequencer top
module ecas_sequencer #(
  parameter int FIFO_DEPTH = `ECAS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serialClk,
  input wire logic frameSel_n,
  input wire logic serialInPin,
  output logic serialOutPin,
  output logic serialOutOe,
  input wire ecas_pkg::ecas_code_type codeIn,
  output logic codeReady,
  output logic [`ECAS_CHAN_W-1:0] muxSel,
  output ecas_pkg::ecas_mode_type convMode
);
  import ecas_pkg::*;

  ecas_rise_type rise_reg, rise_next;
  ecas_chan_type chan_reg, chan_next;
  ecas_fall_type fall_reg, fall_next;
  ecas_hs_type hs_reg, hs_next;
  ecas_core_type core_reg, core_next;
  logic [7:0] ctrlByte;
  logic fresh;
  logic fifoOutValid;
  logic [`ECAS_RESULT_W-1:0] fifoOutData;
  logic fifoOutReady;
  logic fifoInReady;

  //////////////////////////////////////////////////////////////////////////
  // Rising edges: cycle count and control byte
  always_comb begin
    rise_next = rise_reg;
    chan_next = chan_reg;
    ctrlByte = {rise_reg.ctrlShift, serialInPin};
    rise_next.riseCnt = rise_reg.riseCnt + 4'h1;
    if (rise_reg.riseCnt <= `ECAS_CTRL_LAST) begin
      rise_next.ctrlShift = ctrlByte[6:0];
    end
    if (rise_reg.riseCnt == `ECAS_CTRL_LAST) begin
      chan_next.nextChan = ctrlByte[`ECAS_CHAN_MSB:`ECAS_CHAN_LSB];
    end
    if (rise_reg.riseCnt == `ECAS_LAST_CYCLE) begin
      chan_next.curChan = chan_reg.nextChan;
    end
  end

  // Frame-select high holds the count at the start
  always_ff @(posedge serialClk or posedge frameSel_n) begin
    if (frameSel_n) begin
      rise_reg <= '0;
    end else begin
      rise_reg <= rise_next;
    end
  end

  // Channel selection survives between frames
  always_ff @(posedge serialClk or negedge arst_n) begin
    if (!arst_n) begin
      chan_reg <= {`ECAS_CHAN_RESET, `ECAS_CHAN_RESET};
    end else begin
      chan_reg <= chan_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Falling edges: track/hold, data out, auto power-down
  always_comb begin
    fall_next = fall_reg;
    hs_next = hs_reg;
    hs_next.holdSync1 = core_reg.holdTgl;
    hs_next.holdSync2 = hs_reg.holdSync1;
    fresh = hs_reg.holdSync2 != hs_reg.ackTgl;
    if (rise_reg.riseCnt < `ECAS_HOLD_START) begin
      fall_next.track = 1'b1;
      fall_next.bitOut = 1'b0;
    end else if (rise_reg.riseCnt == `ECAS_HOLD_START) begin
      fall_next.track = 1'b0;
      fall_next.bitOut = 1'b0;
      fall_next.outWord = fresh ? core_reg.resultHold : '0;
      if (fresh) begin
        hs_next.ackTgl = ~hs_reg.ackTgl;
      end
    end else begin
      fall_next.bitOut = fall_reg.outWord[`ECAS_RESULT_W-1];
      fall_next.outWord = {fall_reg.outWord[`ECAS_RESULT_W-2:0], 1'b0};
    end
    fall_next.pdAuto = rise_reg.riseCnt == `ECAS_LAST_CYCLE;
  end

  // Released reset counts as the first falling edge
  always_ff @(negedge serialClk or posedge frameSel_n) begin
    if (frameSel_n) begin
      fall_reg <= '{outWord: '0, bitOut: 1'b0, track: 1'b1,
                    pdAuto: 1'b0};
    end else begin
      fall_reg <= fall_next;
    end
  end

  // Result handshake, link side
  always_ff @(negedge serialClk or negedge arst_n) begin
    if (!arst_n) begin
      hs_reg <= '0;
    end else begin
      hs_reg <= hs_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Core clock: synchronisers, result hand-off, mode outputs
  assign fifoOutReady = core_reg.holdTgl == core_reg.ackSync[1];

  always_comb begin
    core_next = core_reg;
    core_next.frameSync = {core_reg.frameSync[0], frameSel_n};
    core_next.trackSync = {core_reg.trackSync[0], fall_reg.track};
    core_next.pdSync = {core_reg.pdSync[0], fall_reg.pdAuto};
    core_next.chanSync = {core_reg.chanSync[0], chan_reg.curChan};
    core_next.ackSync = {core_reg.ackSync[0], hs_reg.ackTgl};
    if (fifoOutValid && fifoOutReady) begin
      core_next.resultHold = fifoOutData;
      core_next.holdTgl = ~core_reg.holdTgl;
    end
    if (core_reg.frameSync[1]) begin
      core_next.mode = MODE_POWERDOWN;
    end else if (core_reg.pdSync[1]) begin
      core_next.mode = MODE_POWERDOWN;
    end else if (core_reg.trackSync[1]) begin
      core_next.mode = MODE_TRACK;
      core_next.muxSel = core_reg.chanSync[1];
    end else begin
      core_next.mode = MODE_HOLD;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_reg <= '{frameSync: 2'h3, trackSync: 2'h0, pdSync: 2'h0,
                    chanSync: '0, ackSync: 2'h0, resultHold: '0,
                    holdTgl: 1'b0, muxSel: `ECAS_CHAN_RESET,
                    mode: MODE_POWERDOWN};
    end else begin
      core_reg <= core_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Result buffer instance
  ecas_fifo #(
    .WIDTH(`ECAS_RESULT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .inValid(codeIn.valid),
    .inData(codeIn.data),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoOutReady)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign serialOutPin = fall_reg.bitOut;
  assign serialOutOe = ~frameSel_n;
  assign codeReady = fifoInReady;
  assign muxSel = core_reg.muxSel;
  assign convMode = core_reg.mode;
endmodule // ecas_sequencer

// file: ecas_checker.sv
`timescale 1ns/100ps
module ecas_checker #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serialClk,
  input wire logic frameSel_n,
  input wire logic serialOutPin,
  input wire logic serialOutOe,
  input wire logic [2:0] muxSel,
  input wire ecas_pkg::ecas_mode_type convMode
);
  import ecas_pkg::*;
  logic [3:0] riseCnt_reg;
  // Serial rises in frame, independent of idle clock level
  always_ff @(posedge serialClk or posedge frameSel_n) begin
    if (frameSel_n) riseCnt_reg <= 4'h0;
    else riseCnt_reg <= riseCnt_reg + 4'h1;
  end
  ////////////////////////////////////////
  oe_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
    serialOutOe == !frameSel_n) else $error("oe wrong");
  idle_low_a: assert property (@(posedge clk) disable iff (!arst_n)
    frameSel_n |-> !serialOutPin) else $error("idle out high");
  idle_pd_a: assert property (@(posedge clk) disable iff (!arst_n)
    frameSel_n [*5] |-> convMode == MODE_POWERDOWN) else $error("no pd");
  track_start_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(frameSel_n) |-> ##[1:6] convMode == MODE_TRACK)
    else $error("no track");
  hold_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(convMode == MODE_HOLD) |-> (convMode == MODE_HOLD) [*8])
    else $error("hold short");
  auto_pd_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(convMode == MODE_HOLD) && !frameSel_n
    |-> convMode == MODE_POWERDOWN) else $error("no auto pd");
  mux_track_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(muxSel) |-> convMode == MODE_TRACK
    || $past(convMode) == MODE_TRACK) else $error("mux moved");
  lead_zero_a: assert property (@(posedge serialClk)
    disable iff (frameSel_n || !arst_n)
    riseCnt_reg < 4'h4 |-> !serialOutPin) else $error("lead bit high");
endmodule // ecas_checker

bind ecas_sequencer ecas_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
  .clk(clk), .arst_n(arst_n), .serialClk(serialClk),
  .frameSel_n(frameSel_n), .serialOutPin(serialOutPin),
  .serialOutOe(serialOutOe), .muxSel(muxSel), .convMode(convMode));

// file: ecas_host_model.sv
`timescale 1ns/100ps
module ecas_host_model (
  output logic serialClk,
  output logic frameSel_n,
  output logic serialInPin,
  input wire logic serialOutPin
);
  logic [15:0] words[$];
  logic [15:0] w;
  // Late start gives select a real rising edge
  initial begin
    #1;
    serialClk = 1'b0;
    frameSel_n = 1'b1;
    serialInPin = 1'b0;
  end
  ////////////////////////////////////////
  // Frame of n conversions, clock high or low at select edges
  task automatic frame(input int n, input logic [7:0] ctl, input logic hi);
    if (hi) begin
      serialClk = 1'b1;
      #24;
    end
    frameSel_n = 1'b0;
    if (hi) begin
      #24 serialClk = 1'b0;
    end
    for (int k = 0; k < n; k++) begin
      for (int i = 0; i < 16; i++) begin
        serialInPin = i < 8 ? ctl[7-i] : ~serialInPin;
        #24 serialClk = 1'b1;
        w[15-i] = serialOutPin;
        #24;
        if (!hi || k < n - 1 || i < 15) begin
          serialClk = 1'b0;
        end
      end
      words.push_back(w);
    end
    #24 frameSel_n = 1'b1;
    #24 serialClk = 1'b0;
  endtask
endmodule // ecas_host_model

// file: test_eight_channel_adc_serial_sequencer.sv
`timescale 1ns/100ps
module test_eight_channel_adc_serial_sequencer;
  import ecas_pkg::*;
  localparam int DEPTH = 32;
  logic clk = 1'b0;
  logic arst_n = 1'b1;
  logic serialClk, frameSel_n, serialInPin, serialOutPin, serialOutOe;
  logic codeReady;
  logic [2:0] muxSel;
  ecas_code_type codeIn = '0;
  ecas_mode_type convMode;
  int errors = 0;
  int compares = 0;
  logic [11:0] sent[$];
  always #4 clk = ~clk;
  ecas_sequencer #(.FIFO_DEPTH(DEPTH)) DUT (.clk(clk), .arst_n(arst_n),
    .serialClk(serialClk), .frameSel_n(frameSel_n),
    .serialInPin(serialInPin), .serialOutPin(serialOutPin),
    .serialOutOe(serialOutOe), .codeIn(codeIn), .codeReady(codeReady),
    .muxSel(muxSel), .convMode(convMode));
  ecas_host_model host (.serialClk(serialClk), .frameSel_n(frameSel_n),
    .serialInPin(serialInPin), .serialOutPin(serialOutPin));
  ////////////////////////////////////////
  task automatic stop_test;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [11:0] d, output logic t);
    @(posedge clk);
    #1 t = codeReady;
    codeIn = {1'b1, d};
    @(posedge clk);
    #1 codeIn.valid = 1'b0;
    if (t) sent.push_back(d);
  endtask
  task automatic drain;
    logic [15:0] e;
    while (host.words.size() > 0) begin
      e = sent.size() > 0 ? {4'h0, sent.pop_front()} : 16'h0;
      cmp(host.words.pop_front(), e);
    end
  endtask
  ////////////////////////////////////////
  task automatic first_conv;
    logic t;
    push(12'ha5c, t);
    host.frame(1, 8'hc7, 1'b0);
    drain;
    cmp({13'h0, muxSel}, 16'h0);
  endtask
  task automatic chan_sweep;
    logic t;
    logic [2:0] k;
    for (int c = 0; c < 8; c++) begin
      k = 3'(c);
      push({9'h100, k}, t);
      push({k, 9'h0f0}, t);
      host.frame(2, {~k[1:0], k, k ^ 3'h5}, c[0]);
      drain;
      cmp({13'h0, muxSel}, {13'h0, k});
    end
  endtask
  task automatic fill_drain;
    logic t;
    int n;
    n = 0;
    t = 1'b1;
    while (t && n < 40) begin
      push(12'(n + 3), t);
      n += int'(t);
    end
    cmp({15'h0, codeReady}, 16'h0);
    cmp({15'h0, n >= DEPTH}, 16'h1);
    host.frame(n + 1, 8'h38, 1'b0);
    drain;
  endtask
  ////////////////////////////////////////
  initial begin
    #2 arst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1 arst_n = 1'b1;
    first_conv;
    chan_sweep;
    fill_drain;
    stop_test;
  end
  initial begin
    #100000;
    errors++;
    stop_test;
  end
endmodule // test_eight_channel_adc_serial_sequencer
